// ==== verilog/outch_map.svh ====
`ifndef OUTCH_MAP_SVH
`define OUTCH_MAP_SVH
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_OCEN 12'h004
`define OFS_FLTMD 12'h008
`define OFS_IDLMD 12'h00C
`define OFS_STAT 12'h010
`define OFS_MASK 12'h014
`define OFS_OUT 12'h018
`define OFS_CNT_SEL 12'h01C
`define OFS_CNT_RD 12'h020
`define OFS_THR_WR 12'h024
`define OFS_DIAG 12'h028
// ctrl fields
`define CTRL_SRC_BIT 0
`define CTRL_SW_HOLD_BIT 1
`define CTRL_AUTO_RST_BIT 2
`define CTRL_CNT_EN_BIT 3
`define CTRL_RESET 32'h0000_0004
// status fields: short, open, count reached, commit done
`define ST_SHORT 0
`define ST_OPEN 1
`define ST_CNT 2
`define ST_COMMIT 3
`define ST_W 4
// commit interval
`define COMMIT_SEC 3600
`define CLK_HZ 40000000
`define THR_RESET 32'hFFFF_FFFF
`endif

// ==== verilog/outch_pkg.sv ====
package outch_pkg;
  // per-channel output policy during fault or idle
  typedef enum logic [1:0] {POL_HOLD, POL_CLEAR, POL_FORCE_ON, POL_RSVD} pol_t;
  typedef enum logic [1:0] {LINK_RUN, LINK_IDLE, LINK_FAULT} link_t;
endpackage : outch_pkg

// ==== verilog/count_mem.sv ====
`timescale 1ns/1ps
// retained counter store, registered read
module count_mem #(
  parameter int DEPTH = 8,
  parameter int W = 32,
  parameter int AW = 3
) (
  input wire logic hclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // blank store as shipped: without this the first restore after power-up loads unknowns
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem[i] = '0;
    end
  end

  // no reset: content models storage that outlives control power
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : count_mem

// ==== verilog/pin_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser, one per bit
module pin_sync #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pin_sync

// ==== verilog/output_channel_diag_failsafe.sv ====
`timescale 1ns/1ps
`include "outch_map.svh"
module output_channel_diag_failsafe
  import outch_pkg::*;
#(
  parameter int NCH = 8,
  parameter int CW = 32,
  parameter int AW = 3,
  parameter longint COMMIT_CYC = longint'(`COMMIT_SEC) * longint'(`CLK_HZ)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NCH-1:0] cmd_out,
  input wire outch_pkg::link_t link_state,
  input wire logic [NCH-1:0] short_sense,
  input wire logic [NCH-1:0] open_sense,
  output logic [NCH-1:0] chan_out,
  output logic irq
);
  import outch_pkg::*;

  logic [NCH-1:0] short_s, open_s;
  logic wr_pend_q, wr_pend_d;
  logic [11:0] wa_q, wa_d;
  logic [31:0] ctrl_q, ctrl_d, ocen_q, ocen_d, fmd_q, fmd_d, imd_q, imd_d;
  logic [31:0] mask_q, mask_d, sel_q, sel_d, rdat_q, rdat_d;
  logic [`ST_W-1:0] stat_q, stat_d;
  logic [NCH-1:0] out_q, out_d, sdiag_q, sdiag_d, odiag_q, odiag_d, cdiag_q, cdiag_d;
  logic [CW-1:0] cnt_q [NCH];
  logic [CW-1:0] cnt_d [NCH];
  logic [CW-1:0] thr_q [NCH];
  logic [CW-1:0] thr_d [NCH];
  logic [63:0] tick_q, tick_d;
  logic loading_q, loading_d, committing_q, committing_d;
  logic [AW:0] ptr_q, ptr_d;
  logic [AW-1:0] rd_ptr_q;
  logic mem_we;
  logic [CW-1:0] mem_rd;
  logic [NCH-1:0] want;

  // fault and sense pins arrive from the field side
  pin_sync #(.W(NCH)) u_short (.hclk(hclk), .hresetn(hresetn), .din(short_sense),
    .dout(short_s));
  pin_sync #(.W(NCH)) u_open (.hclk(hclk), .hresetn(hresetn), .din(open_sense),
    .dout(open_s));

  count_mem #(.DEPTH(NCH), .W(CW), .AW(AW)) u_mem (
    .hclk(hclk),
    .we(mem_we),
    .waddr(ptr_q[AW-1:0]),
    .wdata(cnt_q[ptr_q[AW-1:0]]),
    .raddr(ptr_d[AW-1:0]),
    .rdata(mem_rd)
  );

  logic addr_ph;
  assign addr_ph = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdat_q;
  assign chan_out = out_q;
  assign irq = |(stat_q & mask_q[`ST_W-1:0]);
  assign mem_we = committing_q && !ptr_q[AW];

  // requested output per channel
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      pol_t p;
      p = POL_HOLD;
      if (ctrl_q[`CTRL_SRC_BIT])
      begin
        p = (link_state == LINK_FAULT) ? pol_t'(fmd_q[2*i +: 2])
                                       : pol_t'(imd_q[2*i +: 2]);
      end
      else
      begin
        p = ctrl_q[`CTRL_SW_HOLD_BIT] ? POL_HOLD : POL_CLEAR;
      end
      if (link_state == LINK_RUN)
      begin
        want[i] = cmd_out[i];
      end
      else
      begin
        unique case (p)
          POL_HOLD: want[i] = out_q[i];
          POL_CLEAR: want[i] = 1'b0;
          POL_FORCE_ON: want[i] = 1'b1;
          default: want[i] = 1'b0;
        endcase
      end
    end
  end

  // bus, diagnostics, counters, commit sequencing
  always_comb
  begin
    logic [`ST_W-1:0] ev;
    logic [31:0] rv;
    ev = '0;
    rv = 32'h0000_0000;
    wr_pend_d = addr_ph && hwrite;
    wa_d = addr_ph ? haddr[11:0] : wa_q;
    ctrl_d = ctrl_q;
    ocen_d = ocen_q;
    fmd_d = fmd_q;
    imd_d = imd_q;
    mask_d = mask_q;
    sel_d = sel_q;
    thr_d = thr_q;
    out_d = want;
    cnt_d = cnt_q;
    tick_d = tick_q + 64'd1;
    loading_d = loading_q;
    committing_d = committing_q;
    ptr_d = ptr_q;
    for (int i = 0; i < NCH; i++)
    begin
      // auto: follow the pin; manual: latch until power reset
      sdiag_d[i] = ctrl_q[`CTRL_AUTO_RST_BIT] ? short_s[i]
                                              : (sdiag_q[i] | short_s[i]);
      odiag_d[i] = ocen_q[i] && !out_q[i] && open_s[i];
      if (!loading_q && (out_d[i] != out_q[i]) && cnt_q[i] != '1)
      begin
        cnt_d[i] = cnt_q[i] + CW'(1);
      end
      cdiag_d[i] = ctrl_q[`CTRL_CNT_EN_BIT] && (cnt_q[i] >= thr_q[i]);
    end
    // restore counts from retained store after reset
    if (loading_q)
    begin
      if (ptr_q != '0)
      begin
        cnt_d[rd_ptr_q] = mem_rd;
      end
      if (ptr_q == (AW+1)'(NCH))
      begin
        loading_d = 1'b0;
        ptr_d = '0;
      end
      else
      begin
        ptr_d = ptr_q + (AW+1)'(1);
      end
      tick_d = '0;
    end
    else if (committing_q)
    begin
      if (ptr_q == (AW+1)'(NCH-1))
      begin
        committing_d = 1'b0;
        ptr_d = '0;
        ev[`ST_COMMIT] = 1'b1;
      end
      else
      begin
        ptr_d = ptr_q + (AW+1)'(1);
      end
    end
    else if (tick_q >= 64'(COMMIT_CYC - 1))
    begin
      tick_d = '0;
      committing_d = 1'b1;
      ptr_d = '0;
    end
    ev[`ST_SHORT] = |(sdiag_d & ~sdiag_q);
    ev[`ST_OPEN] = |(odiag_d & ~odiag_q);
    ev[`ST_CNT] = |(cdiag_d & ~cdiag_q);
    stat_d = stat_q;
    if (wr_pend_q)
    begin
      unique case (wa_q)
        `OFS_CTRL: ctrl_d = hwdata;
        `OFS_OCEN: ocen_d = hwdata;
        `OFS_FLTMD: fmd_d = hwdata;
        `OFS_IDLMD: imd_d = hwdata;
        `OFS_STAT: stat_d = stat_q & ~hwdata[`ST_W-1:0];
        `OFS_MASK: mask_d = hwdata;
        `OFS_CNT_SEL: sel_d = hwdata;
        `OFS_THR_WR: thr_d[sel_q[AW-1:0]] = CW'(hwdata);
        default: ;
      endcase
    end
    stat_d = stat_d | ev; // set wins over clear
    if (addr_ph && !hwrite)
    begin
      unique case (haddr[11:0])
        `OFS_CTRL: rv = ctrl_q;
        `OFS_OCEN: rv = ocen_q;
        `OFS_FLTMD: rv = fmd_q;
        `OFS_IDLMD: rv = imd_q;
        `OFS_STAT: rv = 32'(stat_q);
        `OFS_MASK: rv = mask_q;
        `OFS_OUT: rv = 32'(out_q);
        `OFS_CNT_SEL: rv = sel_q;
        `OFS_CNT_RD: rv = 32'(cnt_q[sel_q[AW-1:0]]);
        `OFS_THR_WR: rv = 32'(thr_q[sel_q[AW-1:0]]);
        `OFS_DIAG: rv = {8'h00, 8'(cdiag_q), 8'(odiag_q), 8'(sdiag_q)};
        default: rv = 32'h0000_0000;
      endcase
    end
    rdat_d = rv;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wa_q <= '0;
      ctrl_q <= `CTRL_RESET;
      ocen_q <= '0;
      fmd_q <= '0;
      imd_q <= '0;
      mask_q <= '0;
      sel_q <= '0;
      rdat_q <= '0;
      stat_q <= '0;
      out_q <= '0;
      sdiag_q <= '0;
      odiag_q <= '0;
      cdiag_q <= '0;
      tick_q <= '0;
      loading_q <= 1'b1;
      committing_q <= 1'b0;
      ptr_q <= '0;
      rd_ptr_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        cnt_q[i] <= '0;
        thr_q[i] <= CW'(`THR_RESET);
      end
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wa_q <= wa_d;
      ctrl_q <= ctrl_d;
      ocen_q <= ocen_d;
      fmd_q <= fmd_d;
      imd_q <= imd_d;
      mask_q <= mask_d;
      sel_q <= sel_d;
      rdat_q <= rdat_d;
      stat_q <= stat_d;
      out_q <= out_d;
      sdiag_q <= sdiag_d;
      odiag_q <= odiag_d;
      cdiag_q <= cdiag_d;
      tick_q <= tick_d;
      loading_q <= loading_d;
      committing_q <= committing_d;
      ptr_q <= ptr_d;
      rd_ptr_q <= ptr_d[AW-1:0];
      cnt_q <= cnt_d;
      thr_q <= thr_d;
    end
  end

  // manual mode: diagnostic never drops while reset is released
  a_short_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (sdiag_q[0] && !ctrl_q[`CTRL_AUTO_RST_BIT]) |=> sdiag_q[0])
    else $error("short diagnostic dropped in manual mode");
  a_short_auto: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_q[`CTRL_AUTO_RST_BIT] && !short_s[0]) |=> !sdiag_q[0])
    else $error("short diagnostic kept in auto mode");
  a_short_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    short_s[0] |=> sdiag_q[0])
    else $error("short not reported");
  a_open_when_on: assert property (@(posedge hclk) disable iff (!hresetn)
    out_q[0] |=> !odiag_q[0])
    else $error("open load flagged while on");
  a_run_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (hresetn && link_state == LINK_RUN) |=> (out_q == $past(cmd_out)))
    else $error("output not following command");
  a_switch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (link_state != LINK_RUN && !ctrl_q[`CTRL_SRC_BIT] && !ctrl_q[`CTRL_SW_HOLD_BIT])
    |=> (out_q == '0))
    else $error("switch clear not applied");
  a_idle_force: assert property (@(posedge hclk) disable iff (!hresetn)
    (link_state == LINK_IDLE && ctrl_q[`CTRL_SRC_BIT] && imd_q[1:0] == 2'h2)
    |=> out_q[0])
    else $error("idle force on not applied");
  a_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (!loading_q && out_d[0] != out_q[0] && cnt_q[0] != '1)
    |=> cnt_q[0] == $past(cnt_q[0]) + CW'(1))
    else $error("transition not counted");
  a_thr_diag: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_q[`CTRL_CNT_EN_BIT] && cnt_q[0] >= thr_q[0]) |=> cdiag_q[0])
    else $error("threshold diagnostic missing");
endmodule : output_channel_diag_failsafe

// ==== tb/fieldbus_relay.sv ====
`timescale 1ns/1ps
// far-side interface unit: hands controller commands and link state to the block
module fieldbus_relay
  import outch_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic hclk,
  input wire logic [NCH-1:0] cmd_req,
  input wire outch_pkg::link_t link_req,
  output logic [NCH-1:0] cmd_out = {NCH{1'b0}},
  output outch_pkg::link_t link_state = LINK_RUN
);
  // one register stage: the unit only updates on its own clock edge, never mid-cycle
  always_ff @(posedge hclk)
  begin
    cmd_out <= cmd_req;
    link_state <= link_req;
  end
endmodule : fieldbus_relay

// ==== tb/output_channel_diag_failsafe_bench.sv ====
`timescale 1ns/1ps
`include "outch_map.svh"
module output_channel_diag_failsafe_bench;
  import outch_pkg::*;
  localparam int NCH = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] base;
  logic [31:0] base1;
  logic [NCH-1:0] cmd_req = 8'h00;
  link_t link_req = LINK_RUN;
  logic [NCH-1:0] cmd_out;
  link_t link_state;
  logic [NCH-1:0] short_sense = 8'h00;
  logic [NCH-1:0] open_sense = 8'h00;
  logic [NCH-1:0] chan_out;
  logic irq;
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 hclk = ~hclk;
  fieldbus_relay #(.NCH(NCH)) relay (.hclk(hclk), .cmd_req(cmd_req), .link_req(link_req),
    .cmd_out(cmd_out), .link_state(link_state));
  // short commit interval so one commit fits in the run
  output_channel_diag_failsafe #(.NCH(NCH), .COMMIT_CYC(200)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmd_out(cmd_out), .link_state(link_state),
    .short_sense(short_sense), .open_sense(open_sense), .chan_out(chan_out), .irq(irq));
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  // a wait that runs out ends the run as a failure instead of hanging
  task automatic wready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask : wready
  // single word transfer: address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    wready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wready();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  // reset, then let the count restore finish before touching anything
  task automatic rst(input int n);
    hresetn <= 1'b0;
    tick(n);
    hresetn <= 1'b1;
    tick(NCH + 4);
  endtask : rst
  task automatic toggle0();
    cmd_req[0] <= ~cmd_req[0];
    tick(4);
  endtask : toggle0
  task automatic t_policy(input logic [31:0] ctrl, input link_t lk);
    logic [NCH-1:0] exp;
    logic [1:0] p;
    logic [7:0] last;
    last = 8'h5A;
    wr(`OFS_CTRL, ctrl);
    wr(`OFS_FLTMD, 32'h0000_E4E4);
    wr(`OFS_IDLMD, 32'h0000_1B1E);
    cmd_req <= last;
    tick(4);
    cmd_req <= 8'hA5;
    link_req <= lk;
    tick(4);
    for (int k = 0; k < NCH; k++)
    begin
      p = (lk == LINK_FAULT) ? 2'(32'hE4E4 >> (2 * k)) : 2'(32'h1B1E >> (2 * k));
      if (ctrl[`CTRL_SRC_BIT] == 1'b0)
        p = ctrl[`CTRL_SW_HOLD_BIT] ? 2'h0 : 2'h1;
      exp[k] = (p == 2'h0) ? last[k] : (p == 2'h2);
    end
    chk(chan_out, exp);
    link_req <= LINK_RUN;
    tick(4);
    chk(chan_out, 8'hA5);
  endtask : t_policy
  task automatic t_short_auto();
    wr(`OFS_MASK, 32'h0000_0001);
    short_sense <= 8'h01;
    tick(6);
    rdc(`OFS_DIAG, 32'h0000_0001);
    chk(irq, 1'b1);
    short_sense <= 8'h00;
    tick(6);
    rdc(`OFS_DIAG, 32'h0000_0000);
    wr(`OFS_STAT, 32'h0000_0001);
    tick(2);
    chk(irq, 1'b0);
  endtask : t_short_auto
  task automatic t_short_manual();
    wr(`OFS_CTRL, 32'h0000_0000);
    short_sense <= 8'h05;
    tick(6);
    short_sense <= 8'h00;
    tick(6);
    wr(`OFS_STAT, 32'h0000_000F);
    rdc(`OFS_DIAG, 32'h0000_0005);
    rst(2);
    rdc(`OFS_DIAG, 32'h0000_0000);
  endtask : t_short_manual
  task automatic t_open();
    wr(`OFS_OCEN, 32'h0000_0002);
    cmd_req <= 8'h06;
    open_sense <= 8'h06;
    tick(6);
    rdc(`OFS_DIAG, 32'h0000_0000);
    cmd_req <= 8'h00;
    tick(6);
    rdc(`OFS_DIAG, 32'h0000_0200);
    open_sense <= 8'h00;
  endtask : t_open
  task automatic t_count();
    int n;
    wr(`OFS_CTRL, 32'h0000_000C);
    cmd_req <= 8'h00;
    tick(4);
    wr(`OFS_CNT_SEL, 32'h0000_0001);
    bus(1'b0, `OFS_CNT_RD, 32'h0000_0000);
    base1 = rd;
    wr(`OFS_CNT_SEL, 32'h0000_0000);
    bus(1'b0, `OFS_CNT_RD, 32'h0000_0000);
    base = rd;
    wr(`OFS_THR_WR, base + 32'h0000_0003);
    wr(`OFS_STAT, 32'h0000_000F);
    toggle0();
    toggle0();
    rdc(`OFS_CNT_RD, base + 32'h0000_0002);
    bus(1'b0, `OFS_STAT, 32'h0000_0000);
    chk(rd[`ST_CNT], 1'b0);
    toggle0();
    bus(1'b0, `OFS_STAT, 32'h0000_0000);
    chk(rd[`ST_CNT], 1'b1);
    rdc(`OFS_CNT_RD, base + 32'h0000_0003);
    wr(`OFS_CNT_SEL, 32'h0000_0001);
    rdc(`OFS_CNT_RD, base1);
    // commit then two unsaved transitions lost across a power reset
    wr(`OFS_STAT, 32'h0000_0008);
    n = 0;
    rd = 32'h0000_0000;
    while (rd[`ST_COMMIT] !== 1'b1 && n < 200)
    begin
      bus(1'b0, `OFS_STAT, 32'h0000_0000);
      n++;
    end
    chk(rd[`ST_COMMIT], 1'b1);
    toggle0();
    toggle0();
    rst(2);
    rdc(`OFS_CNT_RD, base + 32'h0000_0003);
  endtask : t_count
  initial
  begin
    tick(12);
    hresetn <= 1'b1;
    tick(NCH + 4);
    rdc(`OFS_CTRL, `CTRL_RESET);
    rdc(`OFS_STAT, 32'h0000_0000);
    wr(12'h3F0, 32'hFFFF_FFFF);
    rdc(12'h3F0, 32'h0000_0000);
    t_short_auto();
    t_open();
    t_policy(32'h0000_0005, LINK_FAULT);
    t_policy(32'h0000_0005, LINK_IDLE);
    t_policy(32'h0000_0006, LINK_FAULT);
    t_policy(32'h0000_0004, LINK_IDLE);
    t_count();
    t_short_manual();
    print_verdict();
  end
endmodule : output_channel_diag_failsafe_bench
